/* rtl/ttr_regs.sv */
`default_nettype none
// Notes on behaviour
// [R1] Writing one to bit 3 of the control register starts a conversion and that bit reads zero.
// [R2] The busy flag at bit 2 stays high for the whole conversion and clears when it ends.
// [R3] The receive path is unavailable while busy, and the host waits for busy to clear.
// [R4] The result is a read-only byte that rises by one per degree Celsius of falling temperature.
// [R5] The sensitivity register selects normal at 0x1B, high at 0x2D, and resets to normal.
// [R6] The host loads 0x5D into amplifier tuning A for full power and restores 0x55 otherwise.
// [R7] The host loads 0x7C into amplifier tuning B for full power and restores 0x70 otherwise.
// [R8] Gain margin means normal at 0x00, low-index margin at 0x20 and standard margin at 0x30.
// [R9] With low-index correction enabled the frequency offset is the register value times 488 Hz.
// [R10] After power-on reset the host waits at least 10 ms before any bus transaction; here the host waits for module_ready, 5 ms after reset by default.
// [R11] The host leaves the reset pin floating during power-on reset; here the host drives it high for 20 clocks.
// [R12] A manual reset is the reset pin driven high for about a hundred microseconds; here the host drives it high for 100 clocks.
// [R13] After a manual reset the host waits 5 ms before accessing the module.
// [R14] Clock output activity shows the module is out of reset and ready.
// [R15] Writes to the busy flag, unused bits and result register change nothing.
module ttr_regs #(
   parameter int CONV_CYCLES  = ttr_pkg::TTR_CONV_CYCLES,
   parameter int READY_CYCLES = ttr_pkg::TTR_READY_CYCLES
) (
   // Clock, reset, enable
   input  wire logic                       clk_sys,
   input  wire logic                       reset,
   input  wire logic                       ce,
   // Serial bus pins
   input  wire ttr_pkg::ttr_spi_in_type    spi_in,
   output logic                            miso_o,
   output logic                            miso_oe,
   // Sensor and radio control inputs
   input  wire logic signed [7:0]          temp_sensor_celsius,
   input  wire logic                       low_index_correction_enable,
   // Radio control outputs
   output logic                            rx_path_available,
   output logic                            sensitivity_high,
   output logic [7:0]                      amp_tuning_value_a,
   output logic [7:0]                      amp_tuning_value_b,
   output ttr_pkg::ttr_gain_mode_type      gain_margin_mode,
   output logic signed [16:0]              freq_offset_hz,
   // Readiness
   output logic                            clock_output_pin,
   output logic                            module_ready
);
   import ttr_pkg::*;

   localparam int CCW = $clog2(CONV_CYCLES + 1);
   localparam int RCW = $clog2(READY_CYCLES + 1);
   localparam int DCW = $clog2(TTR_CLOCK_OUTPUT_PIN_HALF + 1);

   ttr_reg_req_type    req;
   logic [6:0]         rd_addr;
   logic [7:0]         rd_data;

   ttr_conv_state_type state_q;
   logic [CCW-1:0]     conv_cnt_q;
   logic [7:0]         temp_result_q;
   logic [7:0]         boost_q, pa_a_q, pa_b_q, gain_q, afc_q;
   logic [7:0]         sens_s1_q, sens_s2_q;
   logic [7:0]         sens_s3_q, sens_hold_q;
   logic               sens_high_q;
   ttr_gain_mode_type  gain_mode_q;
   logic signed [16:0] freq_off_q;
   logic [RCW-1:0]     ready_cnt_q;
   logic               ready_q;
   logic [DCW-1:0]     div_cnt_q;
   logic               clock_output_pin_q;

   // Falling temperature means a rising code
   function automatic logic [7:0] temp_to_reading(input logic [7:0] celsius);
      temp_to_reading = TTR_TEMP_BASE - celsius;
   endfunction

   function automatic ttr_gain_mode_type gain_decode(input logic [7:0] v);
      if (v == TTR_GAIN_NORMAL_VAL) begin
         gain_decode = TTR_GAIN_NORMAL;
      end else if (v == TTR_GAIN_LOW_IDX_VAL) begin
         gain_decode = TTR_GAIN_LOW_INDEX;
      end else if (v == TTR_GAIN_STD_VAL) begin
         gain_decode = TTR_GAIN_STANDARD;
      end else begin
         gain_decode = TTR_GAIN_CUSTOM;
      end
   endfunction

   ttr_spi_slave u_spi (
      .clk_sys (clk_sys),
      .reset   (reset),
      .ce      (ce),
      .spi_in  (spi_in),
      .miso_o  (miso_o),
      .miso_oe (miso_oe),
      .req     (req),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // Write decode
   wire busy        = (state_q == TTR_ST_CONVERT);
   wire wr_ctrl     = req.wr & (req.addr == TTR_ADDR_TEMP_CTRL);
   wire wr_boost    = req.wr & (req.addr == TTR_ADDR_RX_BOOST);
   wire wr_pa_a     = req.wr & (req.addr == TTR_ADDR_PA_TUNE_A);
   wire wr_pa_b     = req.wr & (req.addr == TTR_ADDR_PA_TUNE_B);
   wire wr_gain     = req.wr & (req.addr == TTR_ADDR_GAIN_MARGIN);
   wire wr_afc      = req.wr & (req.addr == TTR_ADDR_FREQ_OFFSET);
   wire start_conv  = wr_ctrl & req.wdata[TTR_BIT_TRIGGER] & ~busy; // R1
   wire conv_done   = busy & (conv_cnt_q == '0);

   // Trigger always reads zero; unused bits read fixed
   wire [7:0] ctrl_rd = {TTR_CTRL_HIGH_BITS, 1'b0, busy, TTR_CTRL_LOW_BITS}; // R1 R15

   // Read mux; unmapped addresses read zero
   assign rd_data = (rd_addr == TTR_ADDR_TEMP_CTRL)   ? ctrl_rd :
                    (rd_addr == TTR_ADDR_TEMP_RESULT) ? temp_result_q :
                    (rd_addr == TTR_ADDR_RX_BOOST)    ? boost_q :
                    (rd_addr == TTR_ADDR_PA_TUNE_A)   ? pa_a_q :
                    (rd_addr == TTR_ADDR_PA_TUNE_B)   ? pa_b_q :
                    (rd_addr == TTR_ADDR_GAIN_MARGIN) ? gain_q :
                    (rd_addr == TTR_ADDR_FREQ_OFFSET) ? afc_q : 8'h00;

   // Sensor word is analog-side and may be caught mid-change, so a code is
   // only kept once it has been seen on two edges in a row
   wire sens_settled = (sens_s2_q == sens_s3_q);
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sens_s1_q   <= 8'h00;
         sens_s2_q   <= 8'h00;
         sens_s3_q   <= 8'h00;
         sens_hold_q <= 8'h00;
      end else if (ce) begin
         sens_s1_q <= temp_sensor_celsius;
         sens_s2_q <= sens_s1_q;
         sens_s3_q <= sens_s2_q;
         if (sens_settled) sens_hold_q <= sens_s2_q;
      end
   end

   // Conversion sequencer; a second trigger while busy is ignored
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q       <= TTR_ST_IDLE;
         conv_cnt_q    <= '0;
         temp_result_q <= TTR_RST_TEMP_RESULT;
      end else if (ce) begin
         case (state_q)
            TTR_ST_IDLE: begin
               if (start_conv) begin
                  state_q    <= TTR_ST_CONVERT; // R2
                  conv_cnt_q <= CCW'(CONV_CYCLES - 1);
               end
            end
            TTR_ST_CONVERT: begin
               if (conv_done) begin
                  state_q       <= TTR_ST_IDLE; // R2
                  temp_result_q <= temp_to_reading(sens_hold_q); // R4
               end else begin
                  conv_cnt_q <= conv_cnt_q - CCW'(1);
               end
            end
            default: state_q <= TTR_ST_IDLE;
         endcase
      end
   end

   // Writable test registers; the result register has no write path
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         boost_q <= TTR_RST_RX_BOOST; // R5
         pa_a_q  <= TTR_RST_PA_TUNE_A;
         pa_b_q  <= TTR_RST_PA_TUNE_B;
         gain_q  <= TTR_RST_GAIN_MARGIN;
         afc_q   <= TTR_RST_FREQ_OFFSET;
      end else if (ce) begin
         if (wr_boost) boost_q <= req.wdata;
         if (wr_pa_a)  pa_a_q  <= req.wdata;
         if (wr_pa_b)  pa_b_q  <= req.wdata;
         if (wr_gain)  gain_q  <= req.wdata;
         if (wr_afc)   afc_q   <= req.wdata;
      end
   end

   // Registered decodes towards the radio
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sens_high_q <= 1'b0;
         gain_mode_q <= TTR_GAIN_STANDARD;
         freq_off_q  <= '0;
      end else if (ce) begin
         sens_high_q <= (boost_q == TTR_RX_BOOST_HIGH); // R5
         gain_mode_q <= gain_decode(gain_q); // R8
         freq_off_q  <= low_index_correction_enable ?
                        17'($signed(afc_q)) * TTR_AFC_STEP_HZ : '0; // R9
      end
   end

   // Ready timer, then a free-running clock output
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ready_cnt_q <= '0;
         ready_q     <= 1'b0;
         div_cnt_q   <= '0;
         clock_output_pin_q    <= 1'b0;
      end else if (ce) begin
         if (!ready_q) begin
            ready_cnt_q <= ready_cnt_q + RCW'(1);
            ready_q     <= (ready_cnt_q == RCW'(READY_CYCLES - 1)); // R14
         end else if (div_cnt_q == DCW'(TTR_CLOCK_OUTPUT_PIN_HALF - 1)) begin
            div_cnt_q <= '0;
            clock_output_pin_q  <= ~clock_output_pin_q; // R14
         end else begin
            div_cnt_q <= div_cnt_q + DCW'(1);
         end
      end
   end

   assign rx_path_available  = ~busy; // R3
   assign sensitivity_high   = sens_high_q;
   assign amp_tuning_value_a = pa_a_q;
   assign amp_tuning_value_b = pa_b_q;
   assign gain_margin_mode   = gain_mode_q;
   assign freq_offset_hz     = freq_off_q;
   assign clock_output_pin   = clock_output_pin_q;
   assign module_ready       = ready_q;

   // Checks
   sequence s_trigger;
      ce && wr_ctrl && req.wdata[TTR_BIT_TRIGGER] && !busy;
   endsequence

   AST_TRIG_START: assert property (@(posedge clk_sys) disable iff (reset) // R1
      s_trigger |=> busy && conv_cnt_q == CCW'(CONV_CYCLES - 1))
      else $error("trigger did not start a conversion");
   AST_TRIG_READS_ZERO: assert property (@(posedge clk_sys) disable iff (reset) // R1
      rd_addr == TTR_ADDR_TEMP_CTRL |->
         !rd_data[TTR_BIT_TRIGGER] && rd_data[TTR_BIT_BUSY] == busy)
      else $error("control register read value wrong");
   AST_BUSY_HOLDS: assert property (@(posedge clk_sys) disable iff (reset) // R2
      busy && conv_cnt_q != '0 |=> busy)
      else $error("busy dropped before conversion end");
   AST_BUSY_CLEARS: assert property (@(posedge clk_sys) disable iff (reset) // R2
      ce && conv_done |=> !busy && rx_path_available)
      else $error("busy not cleared at conversion end");
   AST_RX_BLOCKED: assert property (@(posedge clk_sys) disable iff (reset) // R3
      busy |-> !rx_path_available)
      else $error("receive path available during conversion");
   AST_RESULT: assert property (@(posedge clk_sys) disable iff (reset) // R4
      ce && conv_done |=> temp_result_q == TTR_TEMP_BASE - $past(sens_hold_q))
      else $error("temperature result wrong");
   AST_SENS: assert property (@(posedge clk_sys) disable iff (reset) // R5
      ce ##1 ce |-> sensitivity_high == ($past(boost_q) == TTR_RX_BOOST_HIGH))
      else $error("sensitivity select mismatch");
   AST_GAIN: assert property (@(posedge clk_sys) disable iff (reset) // R8
      ce && gain_q == TTR_GAIN_LOW_IDX_VAL |=> gain_margin_mode == TTR_GAIN_LOW_INDEX)
      else $error("gain margin mode mismatch");
   AST_AFC: assert property (@(posedge clk_sys) disable iff (reset) // R9
      ce && low_index_correction_enable |=>
         freq_offset_hz == 17'($signed($past(afc_q))) * TTR_AFC_STEP_HZ)
      else $error("frequency offset wrong");
   AST_CLOCK_OUTPUT_PIN_QUIET: assert property (@(posedge clk_sys) disable iff (reset) // R14
      !module_ready |-> !clock_output_pin)
      else $error("clock output active before ready");
   AST_RO_RESULT: assert property (@(posedge clk_sys) disable iff (reset) // R15
      req.wr && req.addr == TTR_ADDR_TEMP_RESULT && !conv_done |=> $stable(temp_result_q))
      else $error("result register changed by a write");
endmodule
`default_nettype wire

/* common/ttr_pkg.sv */
`default_nettype none
package ttr_pkg;
   // Register offsets on the serial bus (7-bit address space)
   localparam logic [6:0] TTR_ADDR_TEMP_CTRL    = 7'h4E;
   localparam logic [6:0] TTR_ADDR_TEMP_RESULT  = 7'h4F;
   localparam logic [6:0] TTR_ADDR_RX_BOOST     = 7'h58;
   localparam logic [6:0] TTR_ADDR_PA_TUNE_A    = 7'h5A;
   localparam logic [6:0] TTR_ADDR_PA_TUNE_B    = 7'h5C;
   localparam logic [6:0] TTR_ADDR_GAIN_MARGIN  = 7'h6F;
   localparam logic [6:0] TTR_ADDR_FREQ_OFFSET  = 7'h71;

   // Field positions in the temperature control/status register
   localparam int         TTR_BIT_TRIGGER       = 3;
   localparam int         TTR_BIT_BUSY          = 2;
   localparam logic [1:0] TTR_CTRL_LOW_BITS     = 2'h1;
   localparam logic [3:0] TTR_CTRL_HIGH_BITS    = 4'h0;

   // Reset and mode values
   localparam logic [7:0] TTR_RST_RX_BOOST      = 8'h1B;
   localparam logic [7:0] TTR_RX_BOOST_HIGH     = 8'h2D;
   localparam logic [7:0] TTR_RST_PA_TUNE_A     = 8'h55;
   localparam logic [7:0] TTR_RST_PA_TUNE_B     = 8'h70;
   localparam logic [7:0] TTR_RST_GAIN_MARGIN   = 8'h30;
   localparam logic [7:0] TTR_GAIN_NORMAL_VAL   = 8'h00;
   localparam logic [7:0] TTR_GAIN_LOW_IDX_VAL  = 8'h20;
   localparam logic [7:0] TTR_GAIN_STD_VAL      = 8'h30;
   localparam logic [7:0] TTR_RST_FREQ_OFFSET   = 8'h00;
   localparam logic [7:0] TTR_RST_TEMP_RESULT   = 8'h00;
   localparam logic [7:0] TTR_TEMP_BASE         = 8'h80;
   localparam logic signed [16:0] TTR_AFC_STEP_HZ = 17'sh001E8;

   // Timing at 100 MHz
   localparam int TTR_CLK_PERIOD_NS   = 10;
   localparam int TTR_CONV_TIME_NS    = 100000;
   localparam int TTR_CONV_CYCLES     = TTR_CONV_TIME_NS / TTR_CLK_PERIOD_NS;
   localparam int TTR_READY_TIME_NS   = 5000000;
   localparam int TTR_READY_CYCLES    = TTR_READY_TIME_NS / TTR_CLK_PERIOD_NS;
   localparam int TTR_CLOCK_OUTPUT_PIN_HALF_NS  = 40;
   localparam int TTR_CLOCK_OUTPUT_PIN_HALF     = TTR_CLOCK_OUTPUT_PIN_HALF_NS / TTR_CLK_PERIOD_NS;

   // Serial pins as seen by the device
   typedef struct packed {
      logic sck;
      logic nss;
      logic mosi;
   } ttr_spi_in_type;

   // Register write request from the serial slave
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ttr_reg_req_type;

   typedef enum logic [1:0] {
      TTR_GAIN_NORMAL,
      TTR_GAIN_LOW_INDEX,
      TTR_GAIN_STANDARD,
      TTR_GAIN_CUSTOM
   } ttr_gain_mode_type;

   typedef enum logic {
      TTR_ST_IDLE,
      TTR_ST_CONVERT
   } ttr_conv_state_type;
endpackage
`default_nettype wire

/* rtl/ttr_spi_slave.sv */
`default_nettype none
module ttr_spi_slave (
   // Clock, reset, enable
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   input  wire logic                     ce,
   // Serial pins
   input  wire ttr_pkg::ttr_spi_in_type  spi_in,
   output logic                          miso_o,
   output logic                          miso_oe,
   // Register side
   output ttr_pkg::ttr_reg_req_type      req,
   output logic [6:0]                    rd_addr,
   input  wire logic [7:0]               rd_data
);
   import ttr_pkg::*;

   ttr_spi_in_type s1_q, s2_q;
   logic           sck_prev_q;
   logic [2:0]     bit_cnt_q;
   logic [6:0]     shift_q;
   logic           addr_phase_q;
   logic           wnr_q;
   logic [6:0]     addr_q;
   logic [7:0]     tx_q;
   logic           load_q;
   logic           skip_fall_q;
   ttr_reg_req_type req_q;

   // Edge detection works on the second stage only
   wire       sck_rise = s2_q.sck & ~sck_prev_q & ~s2_q.nss;
   wire       sck_fall = ~s2_q.sck & sck_prev_q & ~s2_q.nss;
   wire [7:0] rx_byte  = {shift_q, s2_q.mosi};
   wire       byte_end = sck_rise & (bit_cnt_q == 3'h7);

   assign rd_addr = addr_q;
   assign req     = req_q;
   assign miso_o  = tx_q[7];
   assign miso_oe = ~s2_q.nss & ~addr_phase_q & ~wnr_q;

   // Two-stage pin synchroniser
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_q <= '{sck: 1'b0, nss: 1'b1, mosi: 1'b0};
         s2_q <= '{sck: 1'b0, nss: 1'b1, mosi: 1'b0};
      end else if (ce) begin
         s1_q <= spi_in;
         s2_q <= s1_q;
      end
   end

   // Frame engine: address byte, then data bytes with auto-increment
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sck_prev_q   <= 1'b0;
         bit_cnt_q    <= 3'h0;
         shift_q      <= 7'h00;
         addr_phase_q <= 1'b1;
         wnr_q        <= 1'b0;
         addr_q       <= 7'h00;
         tx_q         <= 8'h00;
         load_q       <= 1'b0;
         skip_fall_q  <= 1'b0;
         req_q        <= '0;
      end else if (ce) begin
         sck_prev_q <= s2_q.sck;
         req_q.wr   <= 1'b0;
         load_q     <= 1'b0;
         if (load_q) begin
            tx_q <= rd_data; // Read data fetched one cycle after address update
         end
         if (s2_q.nss) begin
            bit_cnt_q    <= 3'h0;
            addr_phase_q <= 1'b1;
            skip_fall_q  <= 1'b0;
         end else if (sck_rise) begin
            shift_q   <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_end) begin
               skip_fall_q <= 1'b1;
               load_q      <= 1'b1;
               if (addr_phase_q) begin
                  wnr_q        <= rx_byte[7];
                  addr_q       <= rx_byte[6:0];
                  addr_phase_q <= 1'b0;
               end else begin
                  req_q.wr    <= wnr_q;
                  req_q.addr  <= addr_q;
                  req_q.wdata <= rx_byte;
                  addr_q      <= addr_q + 7'h01;
               end
            end
         end else if (sck_fall) begin
            // The edge right after a byte must not eat the freshly loaded MSB
            if (skip_fall_q) begin
               skip_fall_q <= 1'b0;
            end else begin
               tx_q <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end
endmodule
`default_nettype wire

/* dv/ttr_host_model.sv */
`default_nettype none
module ttr_host_model (
   // Clock
   input  wire logic                  clk_sys,
   // Serial pins
   output var ttr_pkg::ttr_spi_in_type spi_in,
   input  wire logic                  miso_o,
   input  wire logic                  miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   import ttr_pkg::*;

   logic miso_last = 1'b0;
   logic miso_pin;

   // Released line shows the inverse of its last bit, so a stale value never passes
   assign miso_pin = miso_oe ? miso_o : ~miso_last;

   always @(posedge clk_sys) begin
      if (miso_oe)
         miso_last <= miso_o;
   end

   initial begin
      spi_in = 3'b010;
   end

   // One byte, MSB first; both sides sample on the rise, half period 10 clk
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_in.mosi = tx[i];
         repeat (10) @(negedge clk_sys);
         rx[i] = miso_pin;
         spi_in.sck = 1'b1;
         repeat (10) @(negedge clk_sys);
         spi_in.sck = 1'b0;
      end
   endtask

   // Frame: address byte, then n data bytes from the top of wd
   task automatic access(input logic wr, input logic [6:0] addr, input int n,
                         input logic [15:0] wd, output logic [15:0] rd);
      logic [7:0] b;
      rd = '0;
      @(negedge clk_sys);
      spi_in.nss = 1'b0;
      repeat (4) @(negedge clk_sys);
      xfer({wr, addr}, b);
      for (int k = 0; k < n; k++) begin
         xfer(wd[15-8*k -: 8], b);
         rd[15-8*k -: 8] = b;
      end
      repeat (10) @(negedge clk_sys);
      spi_in.nss = 1'b1;
      repeat (6) @(negedge clk_sys); // Gap above the 4 clk minimum
   endtask
endmodule
`default_nettype wire

/* dv/temp_test_regs_and_reset_tb.sv */
`default_nettype none
module temp_test_regs_and_reset_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ttr_pkg::*;

   localparam int CONV  = 600;
   localparam int READY = 16;
   localparam int LIMIT = 30000; // Nearly three times the expected run

   logic                      clk_sys;
   logic                      reset;
   logic                      ce;
   logic                      clk_v;
   logic signed [7:0]         temp_c;
   logic                      lic_en;
   ttr_spi_in_type            spi_in;
   logic                      miso_o;
   logic                      miso_oe;
   logic                      rx_path_available;
   logic                      sensitivity_high;
   logic [7:0]                amp_a;
   logic [7:0]                amp_b;
   ttr_gain_mode_type         gain_mode;
   logic signed [16:0]        freq_hz;
   logic                      clock_output_pin;
   logic                      module_ready;
   int                        n_errors = 0;
   int                        cmp_count = 0;
   int                        cycles = 0;
   int                        busy_cnt = 0;

   ttr_regs #(.CONV_CYCLES(CONV), .READY_CYCLES(READY)) DUT (
      .clk_sys(clk_sys), .reset(reset), .ce(ce), .spi_in(spi_in),
      .miso_o(miso_o), .miso_oe(miso_oe), .temp_sensor_celsius(temp_c),
      .low_index_correction_enable(lic_en), .rx_path_available(rx_path_available),
      .sensitivity_high(sensitivity_high), .amp_tuning_value_a(amp_a),
      .amp_tuning_value_b(amp_b), .gain_margin_mode(gain_mode),
      .freq_offset_hz(freq_hz), .clock_output_pin(clock_output_pin),
      .module_ready(module_ready));

   ttr_host_model host (
      .clk_sys(clk_sys), .spi_in(spi_in), .miso_o(miso_o), .miso_oe(miso_oe));

   always #5 clk_sys = ~clk_sys;

   // Cycle ceiling and busy length monitor
   always @(posedge clk_sys) begin
      cycles++;
      if (rx_path_available === 1'b0)
         busy_cnt++;
      if (cycles == LIMIT) begin
         n_errors++;
         $display("CHECK FAILED at %0t: run did not finish in time", $time);
         end_sim();
      end
   end

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      host.access(1'b1, a, 1, {d, 8'h00}, r);
   endtask

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      logic [15:0] r;
      host.access(1'b0, a, 1, 16'h0000, r);
      check(17'(r[15:8]), 17'(exp), "register read");
   endtask

   // Host waits on module_ready instead of a fixed delay, then checks clock output activity
   task automatic wait_ready();
      logic v;
      for (int i = 0; i < READY + 20 && module_ready !== 1'b1; i++) begin
         check(17'(clock_output_pin), 17'h0, "clock out idle before ready");
         @(negedge clk_sys);
      end
      check(17'(module_ready), 17'h1, "ready");
      v = clock_output_pin;
      repeat (5) @(negedge clk_sys);
      check({16'h0000, clock_output_pin}, {16'h0000, ~v}, "clock out active");
   endtask

   // Conversion: busy while running, result = base minus degrees
   task automatic convert(input logic signed [7:0] t, input logic [7:0] exp);
      logic [15:0] r;
      temp_c = t;
      busy_cnt = 0;
      wr(TTR_ADDR_TEMP_CTRL, 8'h08);
      host.access(1'b0, TTR_ADDR_TEMP_CTRL, 1, 16'h0000, r);
      check(17'(r[15:8]), 17'h05, "busy, trigger reads zero");
      check(17'(rx_path_available), 17'h0, "receive blocked");
      for (int i = 0; i < CONV + 20 && rx_path_available !== 1'b1; i++)
         @(negedge clk_sys);
      check(17'(busy_cnt), 17'(CONV), "busy length");
      host.access(1'b0, TTR_ADDR_TEMP_CTRL, 2, 16'h0000, r);
      check(17'(r), 17'({8'h01, exp}), "idle status and result");
   endtask

   logic [6:0]        ra [6] = '{7'h4E, 7'h58, 7'h5A, 7'h5C, 7'h6F, 7'h71};
   logic [7:0]        rv [6] = '{8'h01, 8'h1B, 8'h55, 8'h70, 8'h30, 8'h00};
   logic [7:0]        gv [4] = '{8'h00, 8'h20, 8'h30, 8'h11};
   ttr_gain_mode_type gm [4] = '{TTR_GAIN_NORMAL, TTR_GAIN_LOW_INDEX,
                                 TTR_GAIN_STANDARD, TTR_GAIN_CUSTOM};

   initial begin
      clk_sys = 1'b0;
      ce = 1'b1;
      // Power-on reset is the host driving the reset pin high for 20 clocks here
      reset = 1'b1;
      temp_c = 8'sd25;
      lic_en = 1'b0;
      repeat (20) @(negedge clk_sys);
      reset = 1'b0;
      wait_ready();
      // Enable low freezes every flop, the clock output included
      ce = 1'b0;
      clk_v = clock_output_pin;
      repeat (9) @(negedge clk_sys);
      check({16'h0000, clock_output_pin}, {16'h0000, clk_v}, "clock out frozen");
      ce = 1'b1;
      for (int k = 0; k < 6; k++) rd_chk(ra[k], rv[k]);
      rd_chk(7'h50, 8'h00);
      // Sensitivity select drives its decoded output
      wr(TTR_ADDR_RX_BOOST, TTR_RX_BOOST_HIGH);
      check(17'(sensitivity_high), 17'h1, "high sensitivity");
      rd_chk(TTR_ADDR_RX_BOOST, 8'h2D);
      // Full power tuning, then back to the receive values
      wr(TTR_ADDR_PA_TUNE_A, 8'h5D);
      wr(TTR_ADDR_PA_TUNE_B, 8'h7C);
      check(17'({amp_a, amp_b}), 17'h5D7C, "full power tuning");
      wr(TTR_ADDR_PA_TUNE_A, 8'h55);
      wr(TTR_ADDR_PA_TUNE_B, 8'h70);
      check(17'({amp_a, amp_b}), 17'h5570, "receive tuning");
      for (int k = 0; k < 4; k++) begin
         wr(TTR_ADDR_GAIN_MARGIN, gv[k]);
         check(17'(gain_mode), 17'(gm[k]), "gain margin mode");
      end
      // Offset in steps of 488 Hz, signed, only while correction is on
      lic_en = 1'b1;
      wr(TTR_ADDR_FREQ_OFFSET, 8'h05);
      check(17'(freq_hz), 17'(2440), "offset five steps");
      wr(TTR_ADDR_FREQ_OFFSET, 8'hFF);
      check(17'(freq_hz), 17'(-488), "offset minus one step");
      lic_en = 1'b0;
      repeat (4) @(negedge clk_sys);
      check(17'(freq_hz), 17'h0, "offset off");
      convert(8'sd25, 8'h67);
      convert(8'sd26, 8'h66);
      // Read-only places ignore writes
      wr(TTR_ADDR_TEMP_RESULT, 8'hAA);
      wr(TTR_ADDR_TEMP_CTRL, 8'hF7);
      rd_chk(TTR_ADDR_TEMP_RESULT, 8'h66);
      rd_chk(TTR_ADDR_TEMP_CTRL, 8'h01);
      check(17'(rx_path_available), 17'h1, "no conversion started");
      // Manual reset mid-run, pulse scaled down from the real length
      reset = 1'b1;
      repeat (100) @(negedge clk_sys);
      reset = 1'b0;
      check(17'(module_ready), 17'h0, "not ready after reset");
      wait_ready();
      rd_chk(TTR_ADDR_RX_BOOST, 8'h1B);
      check(17'(sensitivity_high), 17'h0, "normal sensitivity after reset");
      end_sim();
   end
endmodule
`default_nettype wire
